// ---- design/apdo_map.vh ----
// Purpose: Register map constants for the auxiliary path and digital output configuration.
// Assumes: Byte addresses are four times the register index.
// Notes:   Included by the register bank module.
`ifndef APDO_MAP_VH
`define APDO_MAP_VH

`define APDO_IDX_RATE        8'h39
`define APDO_IDX_PATH        8'h3A
`define APDO_IDX_FAMILY      8'h3B

`define APDO_RST_RATE        8'h00
`define APDO_RST_PATH        8'h40
`define APDO_RST_FAMILY      8'h00

`define APDO_MASK_RATE       8'hF0
`define APDO_MASK_PATH       8'hCF
`define APDO_MASK_FAMILY     8'h60

`define APDO_BIT_FOLLOW      7
`define APDO_BIT_FEEDBACK    6
`define APDO_BIT_OUT_B_FAM   6
`define APDO_BIT_OUT_A_FAM   5
`define APDO_POS_REF_LO      0
`define APDO_POS_OUT_A_RATE  4
`define APDO_POS_OUT_B_RATE  6

`define APDO_REF_AUTO        4'h0
`define APDO_REF_CODE_0      4'h3
`define APDO_REF_CODE_1      4'h4
`define APDO_REF_CODE_2      4'h8
`define APDO_REF_CODE_3      4'h9

`define APDO_HTRANS_NONSEQ   2'h2
`define APDO_HTRANS_SEQ      2'h3

`endif

// ---- design/apdo_regs.v ----
// Purpose: AHB-Lite register bank steering the secondary path and two auxiliary outputs.
// Assumes: Single-word transfers; zero wait states; response always OKAY.
// Notes:   Configuration fields leave the block as registered outputs.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "apdo_map.vh"

// Contract
// - Bit 6 of the path register selects digital feedback when set and analog when clear.
// - The forced reference field selects automatic mode at zero and forces one of four inputs.
// - Bit 6 of the family register picks the 2048-based family for output B when set.
// - Bit 5 of the family register picks the 2048-based family for output A when set.
// - Bits 7:6 of the rate register choose one of four output B rates in its family.
// - Bits 5:4 of the rate register choose one of four output A rates in its family.
module apdo_regs (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         aux_follows_main_sel,
    output reg         aux_feedback_mode_sel,
    output reg         aux_ref_forced,
    output reg  [1:0]  aux_ref_index,
    output reg         out_a_family_sel,
    output reg         out_b_family_sel,
    output reg  [1:0]  out_a_rate_code,
    output reg  [1:0]  out_b_rate_code
);

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    reg        wr_pend_q;
    reg [7:0]  wr_idx_q;
    reg [7:0]  rate_q;
    reg [7:0]  path_q;
    reg [7:0]  family_q;

    wire       take = hsel && hready && (htrans == `APDO_HTRANS_NONSEQ ||
                                         htrans == `APDO_HTRANS_SEQ);
    wire [7:0] idx  = haddr[9:2];

    // Reads return zero in the unused positions because stores keep only used bits.
    function [7:0] read_reg;
        input [7:0] i;
        begin
            case (i)
                `APDO_IDX_RATE:   read_reg = rate_q;
                `APDO_IDX_PATH:   read_reg = path_q;
                `APDO_IDX_FAMILY: read_reg = family_q;
                default:          read_reg = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Reset images of the stored registers
    // ------------------------------------------------------------------
    // Outputs reset to the fields of these images so that they agree with
    // what software reads back straight after reset.
    localparam [7:0] RST_RATE   = `APDO_RST_RATE;
    localparam [7:0] RST_PATH   = `APDO_RST_PATH;
    localparam [7:0] RST_FAMILY = `APDO_RST_FAMILY;

    // ------------------------------------------------------------------
    // Field helpers
    // ------------------------------------------------------------------
    // Clears every position that a register does not implement.
    function [7:0] keep_used;
        input [7:0] data;
        input [7:0] mask;
        begin
            keep_used = data & mask;
        end
    endfunction

    // High for the four codes that force one input reference.
    function ref_listed;
        input [3:0] code;
        begin
            case (code)
                `APDO_REF_CODE_0: ref_listed = 1'b1;
                `APDO_REF_CODE_1: ref_listed = 1'b1;
                `APDO_REF_CODE_2: ref_listed = 1'b1;
                `APDO_REF_CODE_3: ref_listed = 1'b1;
                default:          ref_listed = 1'b0;
            endcase
        end
    endfunction

    // Slot of the forced input reference, zero when selection is automatic.
    function [1:0] ref_slot;
        input [3:0] code;
        begin
            case (code)
                `APDO_REF_CODE_0: ref_slot = 2'h0;
                `APDO_REF_CODE_1: ref_slot = 2'h1;
                `APDO_REF_CODE_2: ref_slot = 2'h2;
                `APDO_REF_CODE_3: ref_slot = 2'h3;
                default:          ref_slot = 2'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Write data phase decode
    // ------------------------------------------------------------------
    // Write data follows its address by one cycle, so the index is held
    // for the data phase and the store happens at its closing edge.
    wire       we_rate   = wr_pend_q && (wr_idx_q == `APDO_IDX_RATE);
    wire       we_path   = wr_pend_q && (wr_idx_q == `APDO_IDX_PATH);
    wire       we_family = wr_pend_q && (wr_idx_q == `APDO_IDX_FAMILY);

    // ------------------------------------------------------------------
    // Register storage and read data
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_idx_q  <= idx;
            // The bank answers at once and always reports OKAY.
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            // A read taken at the closing edge of a write to the same register
            // still returns the old value; one idle cycle between shows the new.
            if (take && !hwrite) begin
                hrdata <= {24'h00_0000, read_reg(idx)};
            end
        end
    end

    // ------------------------------------------------------------------
    // Register stores
    // ------------------------------------------------------------------
    // Each register keeps only its implemented bits, so unused positions read zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_q <= RST_RATE;
        end else if (we_rate) begin
            rate_q <= keep_used(hwdata[7:0], `APDO_MASK_RATE);
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            path_q <= RST_PATH;
        end else if (we_path) begin
            path_q <= keep_used(hwdata[7:0], `APDO_MASK_PATH);
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            family_q <= RST_FAMILY;
        end else if (we_family) begin
            family_q <= keep_used(hwdata[7:0], `APDO_MASK_FAMILY);
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------------
    wire [3:0] ref_code = path_q[`APDO_POS_REF_LO +: 4];

    // Secondary path controls follow the stored path register by one cycle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_follows_main_sel  <= RST_PATH[`APDO_BIT_FOLLOW];
            aux_feedback_mode_sel <= RST_PATH[`APDO_BIT_FEEDBACK];
            aux_ref_forced        <= 1'b0;
            aux_ref_index         <= 2'h0;
        end else begin
            aux_follows_main_sel  <= path_q[`APDO_BIT_FOLLOW];
            aux_feedback_mode_sel <= path_q[`APDO_BIT_FEEDBACK];
            aux_ref_forced        <= ref_listed(ref_code);
            aux_ref_index         <= ref_slot(ref_code);
        end
    end

    // ------------------------------------------------------------------
    // Auxiliary output configuration
    // ------------------------------------------------------------------
    // The family and rate fields pass straight through so that the clock
    // generators see them from flip-flops, one cycle after the store.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_a_family_sel <= RST_FAMILY[`APDO_BIT_OUT_A_FAM];
            out_b_family_sel <= RST_FAMILY[`APDO_BIT_OUT_B_FAM];
            out_a_rate_code  <= RST_RATE[`APDO_POS_OUT_A_RATE +: 2];
            out_b_rate_code  <= RST_RATE[`APDO_POS_OUT_B_RATE +: 2];
        end else begin
            out_b_family_sel <= family_q[`APDO_BIT_OUT_B_FAM];
            out_a_family_sel <= family_q[`APDO_BIT_OUT_A_FAM];
            out_b_rate_code  <= rate_q[`APDO_POS_OUT_B_RATE +: 2];
            out_a_rate_code  <= rate_q[`APDO_POS_OUT_A_RATE +: 2];
        end
    end

endmodule

// ---- tb/apdo_regs_checker.sv ----
// Purpose: Concurrent checks on the configuration register bank.
// Assumes: Zero wait states; outputs settle two edges after a data phase.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/100ps
module apdo_regs_checker (
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hwdata,
    input logic        hreadyout,
    input logic        hresp,
    input logic        aux_follows_main_sel,
    input logic        aux_feedback_mode_sel,
    input logic        aux_ref_forced,
    input logic [1:0]  aux_ref_index,
    input logic        out_a_family_sel,
    input logic        out_b_family_sel,
    input logic [1:0]  out_a_rate_code,
    input logic [1:0]  out_b_rate_code
);
    logic [7:0] wr_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Index of the write whose data phase is under way, zero otherwise.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wr_q <= 8'h00;
        else wr_q <= (hsel && htrans[1] && hwrite) ? haddr[9:2] : 8'h00;
    follow_main_a:
        assert property (wr_q == 8'h3A |->
            ##2 aux_follows_main_sel == $past(hwdata[7], 2)) else $error("follow");
    feedback_mode_a:
        assert property (wr_q == 8'h3A |->
            ##2 aux_feedback_mode_sel == $past(hwdata[6], 2)) else $error("feedback");
    forced_ref_a:
        assert property (wr_q == 8'h3A && hwdata[3:0] == 4'h8 |->
            ##2 aux_ref_forced && aux_ref_index == 2'h2) else $error("ref");
    family_b_a:
        assert property (wr_q == 8'h3B |->
            ##2 out_b_family_sel == $past(hwdata[6], 2)) else $error("fam b");
    family_a_a:
        assert property (wr_q == 8'h3B |->
            ##2 out_a_family_sel == $past(hwdata[5], 2)) else $error("fam a");
    rate_b_a:
        assert property (wr_q == 8'h39 |->
            ##2 out_b_rate_code == $past(hwdata[7:6], 2)) else $error("rate b");
    rate_a_a:
        assert property (wr_q == 8'h39 |->
            ##2 out_a_rate_code == $past(hwdata[5:4], 2)) else $error("rate a");
    unlisted_ref_a:
        assert property (wr_q == 8'h3A && !(hwdata[3:0] inside {4'h3, 4'h4, 4'h8, 4'h9}) |->
            ##2 !aux_ref_forced && aux_ref_index == 2'h0) else $error("unlisted ref");
    bus_okay_a:
        assert property (hreadyout && !hresp) else $error("bus");
endmodule
bind apdo_regs apdo_regs_checker chk (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hwdata                (hwdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .aux_follows_main_sel  (aux_follows_main_sel),
    .aux_feedback_mode_sel (aux_feedback_mode_sel),
    .aux_ref_forced        (aux_ref_forced),
    .aux_ref_index         (aux_ref_index),
    .out_a_family_sel      (out_a_family_sel),
    .out_b_family_sel      (out_b_family_sel),
    .out_a_rate_code       (out_a_rate_code),
    .out_b_rate_code       (out_b_rate_code)
);

// ---- tb/apdo_regs_tb_top.sv ----
// Purpose: Directed bus test of the configuration register bank.
// Assumes: Byte address is four times the register index.
// Notes:   Every wait is bounded.
`timescale 1ns/100ps
module apdo_regs_tb_top;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, fol, fbk, frc, fa, fb;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0, idx, ra, rb;
    logic        hreadyout, hresp;
    logic [3:0]  codes[5] = '{4'h0, 4'h3, 4'h4, 4'h8, 4'h9};
    int          miscompares = 0, cmp_count = 0;
    apdo_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .aux_follows_main_sel(fol),
        .aux_feedback_mode_sel(fbk), .aux_ref_forced(frc), .aux_ref_index(idx),
        .out_a_family_sel(fa), .out_b_family_sel(fb), .out_a_rate_code(ra), .out_b_rate_code(rb));
    initial forever #50 hclk = ~hclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Waits for hready; values are taken in the cycle that ends at the edge.
    task automatic phase;
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            r = hrdata;
            rdy = hreadyout;
            @(posedge hclk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            miscompares++;
            give_verdict;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, a, 2'h0};
        phase;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        phase;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk({fol, fbk, frc, idx, fa, fb, ra, rb}, 32'h200);
        rd(8'h39, 32'h0);
        rd(8'h3A, 32'h40);
        rd(8'h3B, 32'h0);
        $display("Test done: reset");
        bus(1'b1, 8'h3A, 32'hFFFFFFFF);
        rd(8'h3A, 32'hCF);
        chk({fol, fbk, frc}, 32'h6);
        foreach (codes[i]) begin
            bus(1'b1, 8'h3A, {28'h0, codes[i]});
            rd(8'h3A, {28'h0, codes[i]});
            chk({fol, fbk, frc, idx}, i == 0 ? 32'h0 : {29'h1, 2'(i - 1)});
        end
        $display("Test done: path");
        bus(1'b1, 8'h3B, 32'hFF);
        rd(8'h3B, 32'h60);
        chk({fb, fa}, 32'h3);
        bus(1'b1, 8'h3B, 32'h40);
        rd(8'h3B, 32'h40);
        chk({fb, fa}, 32'h2);
        bus(1'b1, 8'h3B, 32'h20);
        rd(8'h3B, 32'h20);
        chk({fb, fa}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h39, {24'h0, 2'(k), 2'(3 - k), 4'hF});
            rd(8'h39, {24'h0, 2'(k), 2'(3 - k), 4'h0});
            chk({rb, ra}, {28'h0, 2'(k), 2'(3 - k)});
        end
        bus(1'b1, 8'h40, 32'hFF);
        rd(8'h40, 32'h0);
        $display("Test done: outputs");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({fol, fbk, frc, idx, fa, fb, ra, rb}, 32'h200);
        hresetn <= 1'b1;
        rd(8'h39, 32'h0);
        rd(8'h3A, 32'h40);
        rd(8'h3B, 32'h0);
        $display("Test done: reset again");
        give_verdict;
    end
endmodule
